// >>> hdl/burst_power_ctrl.sv
// Burst power sequencing, strap defaults, resets, bias and test modes.
// Assumes rst_n_i is the hardware reset pin already timed to clk_i, and
// that the strap, enable, sample clock, serial and tx_port_i pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
module burst_power_ctrl
	import burst_power_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic mode_strap_i,
	input wire logic config_strap_i,
	input wire logic transmit_burst_enable_i,
	input wire logic receive_burst_enable_i,
	input wire logic transmit_sample_clock_i,
	input wire logic serial_port_select_n_i,
	input wire logic serial_clock_i,
	input wire logic serial_data_i,
	output logic serial_data_o,
	output logic serial_data_oe_o,
	input wire logic [5:0] tx_port_i,
	input wire logic [5:0] rx_word_i,
	input wire logic [9:0] tx_word_i,
	input wire logic [9:0] converter_data_i,
	output logic [5:0] rx_port_o,
	output logic rx_port_oe_o,
	output logic [9:0] filter_in_o,
	output logic filter_flush_o,
	output logic full_duplex_o,
	output logic tx_analog_power_on_o,
	output logic tx_filter_power_on_o,
	output logic rx_power_on_o,
	output logic calibration_start_o,
	output logic [2:0] first_gain_amplifier_bias_o,
	output logic [1:0] second_gain_amplifier_bias_o,
	output logic [2:0] converter_bias_o
);
	localparam int NPIN = 8;
	logic [NPIN-1:0] pin_lvl;
	logic [NPIN-1:0] pin_rise;
	logic [NPIN-1:0] pin_fall;
	logic [5:0] tx_port_s;
	logic transmit_burst_enable_s;
	logic receive_burst_enable_s;
	logic transmit_sample_clock_rise;
	logic transmit_burst_enable_rise;
	logic transmit_burst_enable_fall;
	logic sel_n_s;
	logic mode_s;
	logic config_s;

	logic mode_q;
	logic soft_rst_q;
	logic rst_seen_q;
	logic cal_start_q;
	logic [7:0] hdp_q;
	logic [7:0] conv_low_q;
	logic [7:0] test_q;
	logic [7:0] bias_q;

	tx_state_e tx_state_q;
	tx_state_e tx_state_d;
	logic [4:0] delay_cnt_q;
	logic [4:0] delay_cnt_d;
	logic [5:0] flush_cnt_q;
	logic flushing_q;
	logic tx_analog_on_q;
	logic tx_filter_on_q;
	logic rx_on_q;
	logic [5:0] rx_port_q;
	logic rx_port_oe_q;
	logic [9:0] filter_in_q;
	logic [2:0] first_bias_q;
	logic [1:0] second_bias_q;
	logic [2:0] conv_bias_q;

	logic half_duplex;
	logic tx_pd_en;
	logic rx_pd_en;
	logic [4:0] tx_delay;

	serial_reg_if reg_bus ();

	pin_sync #(.W(NPIN)) u_pin_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.pin_i({transmit_sample_clock_i, transmit_burst_enable_i,
			receive_burst_enable_i, serial_port_select_n_i,
			serial_clock_i, serial_data_i, mode_strap_i, config_strap_i}),
		.level_o(pin_lvl),
		.rise_o(pin_rise),
		.fall_o(pin_fall)
	);

	pin_sync #(.W(6)) u_tx_port_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.pin_i(tx_port_i),
		.level_o(tx_port_s),
		.rise_o(),
		.fall_o()
	);

	assign transmit_sample_clock_rise = pin_rise[7];
	assign transmit_burst_enable_s = pin_lvl[6];
	assign transmit_burst_enable_rise = pin_rise[6];
	assign transmit_burst_enable_fall = pin_fall[6];
	assign receive_burst_enable_s = pin_lvl[5];
	assign sel_n_s = pin_lvl[4];
	assign mode_s = pin_lvl[1];
	assign config_s = pin_lvl[0];

	// Select held high keeps every frame out, so straps alone
	serial_port_slave u_serial (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.select_n_i(sel_n_s),
		.sclk_rise_i(pin_rise[3]),
		.sclk_fall_i(pin_fall[3]),
		.sdio_i(pin_lvl[2]),
		.sdio_o(serial_data_o),
		.sdio_oe_o(serial_data_oe_o),
		.bus(reg_bus.slave)
	);

	// Interface choice is latched under reset so a moving strap cannot
	// change the data port mid-burst
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || soft_rst_q)
			mode_q <= mode_s;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			soft_rst_q <= 1'b0;
		else
			soft_rst_q <= reg_bus.wr_stb
				&& reg_bus.addr == ADDR_SOFT_RESET
				&& reg_bus.wdata[SOFT_RESET_BIT];
	end

	// Only the hardware reset release launches calibration
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			rst_seen_q <= 1'b0;
			cal_start_q <= 1'b0;
		end
		else
		begin
			rst_seen_q <= 1'b1;
			cal_start_q <= !rst_seen_q;
		end
	end

	// Reset takes effect on the first edge with rst_n_i low
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || soft_rst_q)
		begin
			hdp_q <= hdp_default(mode_s, config_s);
			conv_low_q <= CONV_LOW_RST;
			test_q <= TEST_RST;
			bias_q <= BIAS_RST;
		end
		else if (reg_bus.wr_stb)
		begin
			case (reg_bus.addr)
				ADDR_HALF_DUPLEX: hdp_q <= reg_bus.wdata;
				ADDR_CONV_LOW: conv_low_q <= reg_bus.wdata;
				ADDR_TEST: test_q <= reg_bus.wdata;
				ADDR_BIAS: bias_q <= reg_bus.wdata;
				default: ;
			endcase
		end
	end

	always_comb
	begin
		case (reg_bus.addr)
			ADDR_HALF_DUPLEX: reg_bus.rdata = hdp_q;
			ADDR_CONV_LOW: reg_bus.rdata = conv_low_q;
			ADDR_TEST: reg_bus.rdata = test_q;
			ADDR_BIAS: reg_bus.rdata = bias_q;
			default: reg_bus.rdata = 8'h00;
		endcase
	end

	assign half_duplex = !mode_q;
	assign tx_pd_en = half_duplex && hdp_q[TX_PD_EN_BIT];
	assign rx_pd_en = half_duplex && hdp_q[RX_PD_EN_BIT];
	assign tx_delay = hdp_q[TX_DELAY_MSB:TX_DELAY_LSB];

	always_comb
	begin
		tx_state_d = tx_state_q;
		delay_cnt_d = delay_cnt_q;
		case (tx_state_q)
			TX_ON:
			begin
				if (tx_pd_en && transmit_burst_enable_fall)
				begin
					delay_cnt_d = 5'h0;
					tx_state_d = (tx_delay == 5'h0) ? TX_OFF : TX_WAIT;
				end
			end
			TX_WAIT:
			begin
				if (!tx_pd_en || transmit_burst_enable_rise)
					tx_state_d = TX_ON;
				else if (transmit_sample_clock_rise)
				begin
					delay_cnt_d = delay_cnt_q + 5'h1;
					if (delay_cnt_q == tx_delay - 5'h1)
						tx_state_d = TX_OFF;
				end
			end
			TX_OFF:
			begin
				if (!tx_pd_en || transmit_burst_enable_rise)
					tx_state_d = TX_ON;
			end
			default: tx_state_d = TX_ON;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			tx_state_q <= TX_ON;
			delay_cnt_q <= '0;
			tx_analog_on_q <= 1'b1;
		end
		else
		begin
			tx_state_q <= tx_state_d;
			delay_cnt_q <= delay_cnt_d;
			tx_analog_on_q <= tx_state_d != TX_OFF;
		end
	end

	// Flush counts transmit clocks from the falling enable; a clock that
	// stops early leaves the flush unfinished and the filter stays powered
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			flush_cnt_q <= FLUSH_CYCLES;
			flushing_q <= 1'b0;
		end
		else if (transmit_burst_enable_s || !tx_pd_en)
		begin
			flush_cnt_q <= transmit_burst_enable_s ? 6'h00 : FLUSH_CYCLES;
			flushing_q <= 1'b0;
		end
		else if (transmit_sample_clock_rise && flush_cnt_q != FLUSH_CYCLES)
		begin
			flush_cnt_q <= flush_cnt_q + 6'h1;
			flushing_q <= flush_cnt_q != FLUSH_CYCLES - 6'h1;
		end
		else
			flushing_q <= flush_cnt_q != FLUSH_CYCLES;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			tx_filter_on_q <= 1'b1;
		else
			tx_filter_on_q <= !(tx_state_d == TX_OFF
				&& flush_cnt_q == FLUSH_CYCLES);
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			rx_on_q <= 1'b1;
		else if (!rx_pd_en)
			rx_on_q <= 1'b1;
		else if (hdp_q[RX_VIA_TX_BIT])
			rx_on_q <= !transmit_burst_enable_s;
		else
			rx_on_q <= receive_burst_enable_s;
	end

	// Filter feed has no reset so stored samples survive either reset
	always_ff @(posedge clk_i)
	begin
		if (flushing_q)
			filter_in_q <= MIDSCALE;
		else if (test_q[ANALOG_LB_BIT])
			filter_in_q <= converter_data_i;
		else
			filter_in_q <= tx_word_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			rx_port_q <= '0;
			rx_port_oe_q <= 1'b0;
		end
		else
		begin
			rx_port_q <= test_q[DIGITAL_LB_BIT] ? tx_port_s : rx_word_i;
			rx_port_oe_q <= !test_q[RX_TRISTATE_BIT];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			first_bias_q <= '0;
			second_bias_q <= '0;
			conv_bias_q <= '0;
		end
		else
		begin
			first_bias_q <= bias_q[FIRST_BIAS_MSB:FIRST_BIAS_LSB];
			second_bias_q <= bias_q[SECOND_BIAS_MSB:SECOND_BIAS_LSB];
			conv_bias_q <= conv_low_q[CONV_LOW_BIT] ? CONV_LOW_CODE
				: bias_q[CONV_BIAS_MSB:CONV_BIAS_LSB];
		end
	end

	assign rx_port_o = rx_port_q;
	assign rx_port_oe_o = rx_port_oe_q;
	assign filter_in_o = filter_in_q;
	assign filter_flush_o = flushing_q;
	assign full_duplex_o = mode_q;
	assign tx_analog_power_on_o = tx_analog_on_q;
	assign tx_filter_power_on_o = tx_filter_on_q;
	assign rx_power_on_o = rx_on_q;
	assign calibration_start_o = cal_start_q;
	assign first_gain_amplifier_bias_o = first_bias_q;
	assign second_gain_amplifier_bias_o = second_bias_q;
	assign converter_bias_o = conv_bias_q;
endmodule : burst_power_ctrl

// >>> hdl/burst_power_pkg.sv
// Constants, register map, strap defaults and state types of the burst
// power, reset and test controller.
// Assumes a single 10 MHz system clock; every strap, enable, clock and serial pin and tx_port_i is synchronised first.
// Functional notes
// - Transmit power-down waits a 5-bit count of transmit clocks, default 31.
// - Filter is fed midscale samples before transmit power-down while clock runs.
// - Rising transmit enable powers transmit path up at once, within 0.5 us.
// - Half-duplex register bit 2 picks transmit or receive enable for receive power.
// - Default with config strap low: transmit enable low powers receive up, high powers it down; config strap high selects receive enable.
// - Receive enable selected: its rise powers receive up, its fall down.
// - Bit 1 clear disables fast transmit power-down, bit 0 fast receive.
// - Bias register fields 7:5, 4:3, 2:0; resets to zero.
// - Converter low-power bit 4 forces converter bias code 011.
// - Mode strap low selects half-duplex, high selects full-duplex.
// - Half-duplex register default derives from mode and configuration straps; the others reset to zero.
// - Serial select strapped high leaves device on strap defaults only.
// - Hardware reset or writing bit 5 of register 0x00 restores defaults.
// - Calibration starts on hardware reset release, never on software reset.
// - No reset clears the transmit interpolation filter contents.
// - Registers return to defaults on the first clock edge with hardware reset asserted.
// - Test bit 7 routes converter output into transmit path before filter.
// - Test bit 6 loops 6-bit transmit port back onto receive port.
// - Test bit 5 places receive port in high impedance.
// - Burst power controls act only with half-duplex interface selected.
// - Falling transmit enable starts delay, then power-down within 100 ns.
package burst_power_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int TX_UP_MAX_NS = 500;
	localparam int TX_UP_MAX_CYC = TX_UP_MAX_NS / CLK_PERIOD_NS;
	localparam int RX_UP_MAX_NS = 2000;
	localparam int RX_UP_MAX_CYC = RX_UP_MAX_NS / CLK_PERIOD_NS;
	localparam int TX_DOWN_MAX_NS = 100;
	localparam int TX_DOWN_MAX_CYC = TX_DOWN_MAX_NS / CLK_PERIOD_NS;
	localparam int HW_RESET_MIN_NS = 50;
	localparam int HW_RESET_MIN_CYC =
		(HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [6:0] ADDR_SOFT_RESET = 7'h00;
	localparam logic [6:0] ADDR_HALF_DUPLEX = 7'h03;
	localparam logic [6:0] ADDR_CONV_LOW = 7'h07;
	localparam logic [6:0] ADDR_TEST = 7'h0D;
	localparam logic [6:0] ADDR_BIAS = 7'h13;

	localparam int SOFT_RESET_BIT = 5;
	localparam int TX_DELAY_MSB = 7;
	localparam int TX_DELAY_LSB = 3;
	localparam int RX_VIA_TX_BIT = 2;
	localparam int TX_PD_EN_BIT = 1;
	localparam int RX_PD_EN_BIT = 0;
	localparam int CONV_LOW_BIT = 4;
	localparam int ANALOG_LB_BIT = 7;
	localparam int DIGITAL_LB_BIT = 6;
	localparam int RX_TRISTATE_BIT = 5;
	localparam int FIRST_BIAS_MSB = 7;
	localparam int FIRST_BIAS_LSB = 5;
	localparam int SECOND_BIAS_MSB = 4;
	localparam int SECOND_BIAS_LSB = 3;
	localparam int CONV_BIAS_MSB = 2;
	localparam int CONV_BIAS_LSB = 0;

	localparam logic [7:0] HDP_RST_HALF = 8'hFF;
	localparam logic [7:0] HDP_RST_HALF_ALT = 8'hFB;
	localparam logic [7:0] HDP_RST_FULL = 8'h00;
	localparam logic [7:0] CONV_LOW_RST = 8'h00;
	localparam logic [7:0] TEST_RST = 8'h00;
	localparam logic [7:0] BIAS_RST = 8'h00;

	localparam logic [2:0] CONV_LOW_CODE = 3'h3;
	localparam logic [5:0] FLUSH_CYCLES = 6'h21;
	localparam logic [9:0] MIDSCALE = 10'h200;
	localparam logic [4:0] SPI_ADDR_LAST = 5'h07;
	localparam logic [4:0] SPI_FRAME_LAST = 5'h0F;
	localparam logic [4:0] SPI_FRAME_BITS = 5'h10;

	typedef enum logic [1:0] {TX_ON, TX_WAIT, TX_OFF} tx_state_e;

	// Strap-chosen default of the half-duplex power register
	function automatic logic [7:0] hdp_default(input logic mode,
		input logic config_pin);
		if (mode)
			hdp_default = HDP_RST_FULL;
		else if (config_pin)
			hdp_default = HDP_RST_HALF_ALT;
		else
			hdp_default = HDP_RST_HALF;
	endfunction : hdp_default
endpackage : burst_power_pkg

// >>> hdl/serial_reg_if.sv
// Register access bundle between the serial port slave and the register file.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface serial_reg_if;
	logic wr_stb;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport slave (output wr_stb, output addr, output wdata, input rdata);
	modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface : serial_reg_if

// >>> hdl/pin_sync.sv
// Two-flop synchroniser with edge pulses for a group of pin inputs.
// Assumes pins are asynchronous to clk_i; edges come from the second flop.
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] level_o,
	output logic [W-1:0] rise_o,
	output logic [W-1:0] fall_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] last_q;

	// Synchroniser runs through reset so straps are settled when captured
	always_ff @(posedge clk_i)
	begin
		meta_q <= pin_i;
		sync_q <= meta_q;
		last_q <= sync_q;
	end

	// History follows the pin in reset, so release shows no false edge
	assign level_o = sync_q;
	assign rise_o = sync_q & ~last_q & {W{rst_n_i}};
	assign fall_o = ~sync_q & last_q & {W{rst_n_i}};
endmodule : pin_sync

// >>> hdl/serial_port_slave.sv
// Serial register port: 16-bit frames, read/write bit, 7-bit address, data.
// Assumes synchronised select, clock edges and data; the serial clock must
// stay well below a quarter of clk_i.
`timescale 1ns/1ps
module serial_port_slave
	import burst_power_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic select_n_i,
	input wire logic sclk_rise_i,
	input wire logic sclk_fall_i,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe_o,
	serial_reg_if.slave bus
);
	logic [4:0] cnt_q;
	logic [6:0] shift_q;
	logic rd_q;
	logic [6:0] addr_q;
	logic [7:0] wdata_q;
	logic wr_q;
	logic [7:0] out_q;
	logic oe_q;

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || select_n_i)
		begin
			cnt_q <= '0;
			shift_q <= '0;
			wr_q <= 1'b0;
		end
		else if (sclk_rise_i && cnt_q < SPI_FRAME_BITS)
		begin
			shift_q <= {shift_q[5:0], sdio_i};
			cnt_q <= cnt_q + 5'h1;
			wr_q <= (cnt_q == SPI_FRAME_LAST) && !rd_q;
		end
		else
			wr_q <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			rd_q <= 1'b0;
			addr_q <= '0;
			wdata_q <= '0;
		end
		else if (!select_n_i && sclk_rise_i)
		begin
			if (cnt_q == SPI_ADDR_LAST)
			begin
				rd_q <= shift_q[6];
				addr_q <= {shift_q[5:0], sdio_i};
			end
			if (cnt_q == SPI_FRAME_LAST)
				wdata_q <= {shift_q[6:0], sdio_i};
		end
	end

	// Read data leaves on falling edges so the master samples on rising ones
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || select_n_i)
		begin
			out_q <= '0;
			oe_q <= 1'b0;
		end
		else if (sclk_fall_i && rd_q)
		begin
			if (cnt_q == SPI_ADDR_LAST + 5'h1)
			begin
				out_q <= bus.rdata;
				oe_q <= 1'b1;
			end
			else if (cnt_q == SPI_FRAME_BITS)
				oe_q <= 1'b0;
			else
				out_q <= {out_q[6:0], 1'b0};
		end
	end

	assign bus.wr_stb = wr_q;
	assign bus.addr = addr_q;
	assign bus.wdata = wdata_q;
	assign sdio_o = out_q[7];
	assign sdio_oe_o = oe_q;
endmodule : serial_port_slave

// >>> bench/burst_power_asserts.sv
// Concurrent checks on the burst power controller's top-level ports.
// Assumes binding onto burst_power_ctrl with its one system clock.
`timescale 1ns/1ps
module burst_power_asserts
	import burst_power_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic transmit_burst_enable_i,
	input wire logic [9:0] filter_in_o,
	input wire logic filter_flush_o,
	input wire logic full_duplex_o,
	input wire logic tx_analog_power_on_o,
	input wire logic tx_filter_power_on_o,
	input wire logic rx_power_on_o,
	input wire logic calibration_start_o,
	input wire logic [2:0] first_gain_amplifier_bias_o,
	input wire logic [2:0] converter_bias_o
);
	// Pin sync plus one flop must stay inside 0.5 us
	localparam int UP_BOUND = 5;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	sequence s_cal_pulse;
		calibration_start_o ##1 !calibration_start_o;
	endsequence
	a_cal_after_release: assert property ($rose(rst_n_i) |-> ##1 s_cal_pulse)
		else $error("no calibration pulse after reset release");
	a_cal_only_hw: assert property (calibration_start_o |->
		!$past(rst_n_i) || !$past(rst_n_i, 2))
		else $error("calibration pulse without hardware reset");
	a_bias_on_release: assert property ($rose(rst_n_i) |->
		first_gain_amplifier_bias_o == 3'h0 && converter_bias_o == 3'h0)
		else $error("bias not cleared by reset");
	a_flush_midscale: assert property (filter_flush_o |=>
		filter_in_o == MIDSCALE)
		else $error("flush without midscale samples");
	a_flush_holds: assert property ($rose(filter_flush_o) |->
		filter_flush_o [*4])
		else $error("flush ended too soon");
	a_filter_after_flush: assert property ($fell(tx_filter_power_on_o) |->
		$past(filter_flush_o) || $past(filter_flush_o, 2))
		else $error("filter powered down without flush");
	a_tx_up_fast: assert property ($rose(transmit_burst_enable_i) |->
		##[0:UP_BOUND] tx_analog_power_on_o)
		else $error("transmit path not powered up in time");
	a_full_powered: assert property (full_duplex_o |->
		tx_analog_power_on_o && rx_power_on_o)
		else $error("burst power-down in full duplex");
	a_full_no_flush: assert property (full_duplex_o |-> !filter_flush_o)
		else $error("flush in full duplex");
endmodule : burst_power_asserts

bind burst_power_ctrl burst_power_asserts i_asserts (
	.clk_i,
	.rst_n_i,
	.transmit_burst_enable_i,
	.filter_in_o,
	.filter_flush_o,
	.full_duplex_o,
	.tx_analog_power_on_o,
	.tx_filter_power_on_o,
	.rx_power_on_o,
	.calibration_start_o,
	.first_gain_amplifier_bias_o,
	.converter_bias_o
);

// >>> bench/baseband_model.sv
// Baseband controller model: transmit sample clock and serial port master.
// Assumes all pins change 1 ns after a system clock edge.
`timescale 1ns/1ps
module baseband_model (
	input wire logic clk_i,
	input wire logic dut_data_i,
	input wire logic dut_data_oe_i,
	output logic sample_clock_o,
	output logic select_n_o,
	output logic sclk_o,
	output logic sdata_o
);
	logic drv = 1'h0;
	logic sel_n = 1'h1;
	logic stuck = 1'h0;
	initial sample_clock_o = 1'h0;
	initial sclk_o = 1'h0;
	// Released line toggles, so a stale bit never reads as valid
	assign sdata_o = dut_data_oe_i ? dut_data_i : drv;
	assign select_n_o = sel_n | stuck;
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick
	// Clock stands low between calls; callers run 33 after enable falls
	task automatic transmit_sample_clock(input int n);
		repeat (n)
		begin
			sample_clock_o = 1'h1;
			tick(4);
			sample_clock_o = 1'h0;
			tick(4);
		end
	endtask : transmit_sample_clock
	task automatic spi(input logic rw, input logic [6:0] a,
		input logic [7:0] d, output logic [7:0] r);
		logic [15:0] f;
		f = {rw, a, d};
		r = 8'h00;
		sel_n = 1'h0;
		for (int i = 15; i >= 0; i--)
		begin
			drv = (rw && i < 8) ? ~drv : f[i];
			tick(4);
			sclk_o = 1'h1;
			tick(2);
			if (i < 8)
				r[i] = sdata_o;
			tick(2);
			sclk_o = 1'h0;
		end
		tick(4);
		sel_n = 1'h1;
		drv = ~drv;
		tick(6);
	endtask : spi
endmodule : baseband_model

// >>> bench/burst_power_reset_test_control_tb_top.sv
// Self-checking bench for the burst power, reset and test controller.
// Assumes the baseband model drives the sample clock and serial port.
`timescale 1ns/1ps
module burst_power_reset_test_control_tb_top
	import burst_power_pkg::*;
;
	logic clk = 1'h0;
	logic rst_n, mode, cfg, transmit_burst_enable, receive_burst_enable;
	logic [5:0] txp, rxw;
	logic [9:0] txw, conv;
	logic txc, sel_n, sck, sdi, sdo, sdo_oe, rxoe, flush, fd, txa, txf, rxp;
	logic cal;
	logic [5:0] rxport;
	logic [9:0] fin;
	logic [2:0] b1, b3;
	logic [1:0] b2;
	int errors = 0;
	int samples_checked = 0;
	int cal_seen = 0;
	int n;
	always #50 clk = ~clk;
	always @(posedge clk)
		if (cal === 1'h1)
			cal_seen++;
	baseband_model i_bb (.clk_i(clk), .dut_data_i(sdo), .dut_data_oe_i(sdo_oe),
		.sample_clock_o(txc), .select_n_o(sel_n), .sclk_o(sck), .sdata_o(sdi));
	burst_power_ctrl i_dut (.clk_i(clk), .rst_n_i(rst_n), .mode_strap_i(mode),
		.config_strap_i(cfg), .transmit_burst_enable_i(transmit_burst_enable),
		.receive_burst_enable_i(receive_burst_enable), .transmit_sample_clock_i(txc),
		.serial_port_select_n_i(sel_n), .serial_clock_i(sck),
		.serial_data_i(sdi), .serial_data_o(sdo), .serial_data_oe_o(sdo_oe),
		.tx_port_i(txp), .rx_word_i(rxw), .tx_word_i(txw),
		.converter_data_i(conv), .rx_port_o(rxport), .rx_port_oe_o(rxoe),
		.filter_in_o(fin), .filter_flush_o(flush), .full_duplex_o(fd),
		.tx_analog_power_on_o(txa), .tx_filter_power_on_o(txf),
		.rx_power_on_o(rxp), .calibration_start_o(cal),
		.first_gain_amplifier_bias_o(b1), .second_gain_amplifier_bias_o(b2),
		.converter_bias_o(b3));
	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		i_bb.spi(1'h0, a, d, r);
		tick(8);
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] r;
		i_bb.spi(1'h1, a, 8'h00, r);
		chk({2'h0, r}, {2'h0, exp});
	endtask : rd
	// Power-up wait is shortened; the model never releases before 20 cycles
	task automatic hw_reset(input logic m, input logic c);
		int k;
		mode = m;
		cfg = c;
		rst_n = 1'h0;
		tick(20);
		k = cal_seen;
		rst_n = 1'h1;
		for (int i = 0; i < 6 && cal_seen == k; i++)
			tick(1);
		if (cal_seen == k)
		begin
			errors++;
			$display("Error at %0t: no calibration start", $time);
			give_verdict();
		end
		tick(3);
	endtask : hw_reset
	initial
	begin
		transmit_burst_enable = 1'h0;
		receive_burst_enable = 1'h0;
		txp = 6'h00;
		rxw = 6'h15;
		txw = 10'h0AA;
		conv = 10'h155;
		hw_reset(1'h0, 1'h0);
		chk(fd, 1'h0);
		rd(7'h03, 8'hFF);
		rd(7'h07, 8'h00);
		rd(7'h0D, 8'h00);
		rd(7'h13, 8'h00);
		rd(7'h55, 8'h00);
		$display("Test defaults done");
		transmit_burst_enable = 1'h1;
		tick(6);
		chk(txa, 1'h1);
		chk(rxp, 1'h0);
		transmit_burst_enable = 1'h0;
		tick(6);
		chk(flush, 1'h1);
		chk(fin, MIDSCALE);
		i_bb.transmit_sample_clock(30);
		chk(txa, 1'h1);
		i_bb.transmit_sample_clock(1);
		chk(txa, 1'h0);
		chk(rxp, 1'h1);
		chk(txf, 1'h1);
		i_bb.transmit_sample_clock(2);
		chk(flush, 1'h0);
		chk(txf, 1'h0);
		$display("Test default delay done");
		wr(7'h03, 8'h17);
		transmit_burst_enable = 1'h1;
		tick(6);
		transmit_burst_enable = 1'h0;
		tick(6);
		i_bb.transmit_sample_clock(1);
		chk(txa, 1'h1);
		i_bb.transmit_sample_clock(1);
		chk(txa, 1'h0);
		i_bb.transmit_sample_clock(31);
		transmit_burst_enable = 1'h1;
		tick(6);
		transmit_burst_enable = 1'h0;
		tick(6);
		i_bb.transmit_sample_clock(1);
		transmit_burst_enable = 1'h1;
		tick(6);
		i_bb.transmit_sample_clock(3);
		chk(txa, 1'h1);
		$display("Test short delay and cancel done");
		wr(7'h03, 8'h03);
		chk(rxp, 1'h0);
		receive_burst_enable = 1'h1;
		tick(6);
		chk(rxp, 1'h1);
		receive_burst_enable = 1'h0;
		tick(6);
		chk(rxp, 1'h0);
		transmit_burst_enable = 1'h0;
		tick(6);
		chk(txa, 1'h0);
		i_bb.transmit_sample_clock(33);
		wr(7'h03, 8'hF8);
		transmit_burst_enable = 1'h1;
		tick(6);
		transmit_burst_enable = 1'h0;
		i_bb.transmit_sample_clock(33);
		chk(txa, 1'h1);
		chk(txf, 1'h1);
		chk(rxp, 1'h1);
		$display("Test receive control done");
		txp = 6'h2A;
		wr(7'h0D, 8'h40);
		chk(rxport, 6'h2A);
		chk(rxoe, 1'h1);
		wr(7'h0D, 8'h20);
		chk(rxoe, 1'h0);
		wr(7'h0D, 8'h80);
		chk(fin, 10'h155);
		chk(rxport, 6'h15);
		conv = 10'h2C3;
		rxw = 6'h0B;
		tick(2);
		chk(fin, 10'h2C3);
		chk(rxport, 6'h0B);
		txw = 10'h13C;
		wr(7'h0D, 8'h00);
		chk(fin, 10'h13C);
		$display("Test loop-back done");
		wr(7'h13, 8'hB5);
		chk(b1, 3'h5);
		chk(b2, 2'h2);
		chk(b3, 3'h5);
		wr(7'h07, 8'h10);
		chk(b3, 3'h3);
		n = cal_seen;
		wr(7'h00, 8'h20);
		rd(7'h13, 8'h00);
		rd(7'h07, 8'h00);
		chk(b3, 3'h0);
		chk(10'(cal_seen - n), 10'h0);
		chk(fin, 10'h13C);
		i_bb.stuck = 1'h1;
		wr(7'h13, 8'hFF);
		i_bb.stuck = 1'h0;
		rd(7'h13, 8'h00);
		$display("Test soft reset done");
		wr(7'h13, 8'h11);
		rst_n = 1'h0;
		tick(2);
		chk(b2, 2'h0);
		chk(b3, 3'h0);
		hw_reset(1'h1, 1'h0);
		chk(fd, 1'h1);
		rd(7'h03, 8'h00);
		wr(7'h03, 8'h07);
		transmit_burst_enable = 1'h1;
		tick(6);
		transmit_burst_enable = 1'h0;
		tick(8);
		chk(txa, 1'h1);
		chk(rxp, 1'h1);
		wr(7'h0D, 8'h20);
		chk(rxoe, 1'h0);
		hw_reset(1'h0, 1'h1);
		rd(7'h03, 8'hFB);
		$display("Test hardware reset done");
		give_verdict();
	end
endmodule : burst_power_reset_test_control_tb_top
